/* File: common/scs_pkg.sv */
package scs_pkg;

  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] TBT_IDX = 8'h36;
  localparam logic [7:0] DIV_IDX = 8'h37;
  localparam logic [7:0] SC1_IDX = 8'h38;
  localparam logic [7:0] SC2_IDX = 8'h39;
  localparam logic [7:0] STAT_IDX = 8'h3a;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] TBT_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] SC1_RST = 8'h00;
  localparam logic [7:0] SC2_RST = 8'h80;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TBT_DIVOUT_ENABLE_BIT = 7;
  localparam int TBT_DIVOUT_FREQ_SEL_LSB = 5;
  localparam int TBT_EN_BIT = 3;
  localparam int TBT_CK_LSB = 0;
  localparam int DIV_DIVIDER_INPUT_SELECT_BIT = 5;
  localparam int SC1_STOP_BIT = 7;
  localparam int SC1_STOP_RELEASE_SELECT_BIT = 6;
  localparam int SC1_RETM_BIT = 5;
  localparam int SC1_OUTEN_BIT = 4;
  localparam int SC1_WUT_LSB = 2;
  localparam int SC2_XEN_BIT = 7;
  localparam int SC2_SYSCK_BIT = 5;
  localparam int SC2_IDLE_BIT = 4;

  // ****************************************
  // timing generator and warm-up, in fc periods
  // ****************************************
  localparam int PRE_STAGES = 3;
  localparam int DIV_STAGES = 21;
  localparam int MC_MAX = 15;
  localparam int WDT_TAP = 15;
  localparam int TMR_TAP = 7;
  localparam int WARM_TAP = 13;
  localparam int DVO_TAP [4] = '{12, 11, 10, 9};
  localparam int TBT_TAP [8] = '{22, 20, 18, 16, 15, 13, 11, 6};
  localparam int WARM_LONG_FC = 196608;
  localparam int WARM_MID_FC = 65536;
  localparam int WARM_SHORT_FC = 16384;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_IDLE = 4'b0010,
    MODE_STOP = 4'b0100,
    MODE_WARM = 4'b1000
  } scs_mode_type;

  typedef struct packed {
    logic osc;
    logic cpu;
    logic wdt;
    logic periph;
    logic portHold;
  } scs_clk_en_type;

  typedef struct packed {
    logic divOut;
    logic tbt;
    logic wdt;
    logic tmr;
    logic warm;
  } scs_tick_type;

endpackage

/* File: hw/scs_clock_standby.sv */
// Our own choice: the Wishbone slave port.
module scs_clock_standby #(
  parameter int unsigned WarmLongCycles = scs_pkg::WARM_LONG_FC,
  parameter int unsigned WarmMidCycles = scs_pkg::WARM_MID_FC,
  parameter int unsigned WarmShortCycles = scs_pkg::WARM_SHORT_FC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic stopReleasePin,
  input wire logic irqPeriph,
  input wire logic irqExt,
  input wire logic interruptMasterEnable,
  input wire logic [3:0] instrLen,
  output scs_pkg::scs_clk_en_type clkEn,
  output scs_pkg::scs_tick_type ticks,
  output logic [1:0] mcState,
  output logic instrDone,
  output logic takeIrq,
  output logic resumeNext,
  output logic sysResetReq,
  output scs_pkg::scs_mode_type mode
);

  localparam int CW = scs_pkg::PRE_STAGES + scs_pkg::DIV_STAGES;

  if (WarmShortCycles < 1 || WarmMidCycles < 1 || WarmLongCycles < 1 ||
      (WarmLongCycles << 1) >= (1 << CW)) begin : g_chk
    $error("warm-up counts out of range");
  end

  // ****************************************
  // register bus
  // ****************************************
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] tbt_q;
  logic divider_input_select_q;
  logic stop_q;
  logic stop_release_select_q;
  logic retm_q;
  logic outen_q;
  logic [1:0] wut_q;
  logic xen_q;
  logic sysck_q;
  logic idle_q;
  logic rst_q;
  logic acc;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wd;
  scs_pkg::scs_mode_type mode_q;
  scs_pkg::scs_mode_type mode_d;

  assign acc = wbCyc && wbStb && !ack_q;
  assign wr = acc && wbWe && wbSel[0];
  assign idx = {2'h0, wbAdr[7:2]};
  assign wd = wbDatW[7:0];
  assign wbAck = ack_q;
  assign wbDatR = rdat_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdat_q <= 32'h0;
    end else if (acc) begin
      if (idx == scs_pkg::TBT_IDX) begin
        rdat_q <= {24'h0, tbt_q};
      end else if (idx == scs_pkg::DIV_IDX) begin
        rdat_q <= {26'h0, divider_input_select_q, 5'h0};
      end else if (idx == scs_pkg::SC1_IDX) begin
        rdat_q <= {24'h0, stop_q, stop_release_select_q, retm_q, outen_q, wut_q, 2'h0};
      end else if (idx == scs_pkg::SC2_IDX) begin
        rdat_q <= {24'h0, xen_q, 1'b0, sysck_q, idle_q, 4'h0};
      end else if (idx == scs_pkg::STAT_IDX) begin
        rdat_q <= {28'h0, mode_q};
      end else begin
        rdat_q <= 32'h0;
      end
    end
  end

  // time base register, bit four held at zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tbt_q <= scs_pkg::TBT_RST;
    end else if (wr && idx == scs_pkg::TBT_IDX) begin
      tbt_q <= {wd[7:5], 1'b0, wd[3:0]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divider_input_select_q <= scs_pkg::DIV_RST[scs_pkg::DIV_DIVIDER_INPUT_SELECT_BIT];
    end else if (wr && idx == scs_pkg::DIV_IDX) begin
      divider_input_select_q <= wd[scs_pkg::DIV_DIVIDER_INPUT_SELECT_BIT];
    end
  end

  // stop bit: a software set wins over the hardware clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_q <= scs_pkg::SC1_RST[scs_pkg::SC1_STOP_BIT];
      stop_release_select_q <= scs_pkg::SC1_RST[scs_pkg::SC1_STOP_RELEASE_SELECT_BIT];
      retm_q <= scs_pkg::SC1_RST[scs_pkg::SC1_RETM_BIT];
      outen_q <= scs_pkg::SC1_RST[scs_pkg::SC1_OUTEN_BIT];
      wut_q <= scs_pkg::SC1_RST[scs_pkg::SC1_WUT_LSB+:2];
    end else if (wr && idx == scs_pkg::SC1_IDX) begin
      stop_q <= wd[scs_pkg::SC1_STOP_BIT] ||
        (stop_q && !(mode_d == scs_pkg::MODE_WARM && mode_q != scs_pkg::MODE_WARM));
      stop_release_select_q <= wd[scs_pkg::SC1_STOP_RELEASE_SELECT_BIT];
      retm_q <= wd[scs_pkg::SC1_RETM_BIT];
      outen_q <= wd[scs_pkg::SC1_OUTEN_BIT];
      wut_q <= wd[scs_pkg::SC1_WUT_LSB+:2];
    end else if (mode_d == scs_pkg::MODE_WARM && mode_q != scs_pkg::MODE_WARM) begin
      stop_q <= 1'b0;
    end
  end

  // oscillator and clock select, rewritten when warm-up ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xen_q <= scs_pkg::SC2_RST[scs_pkg::SC2_XEN_BIT];
      sysck_q <= scs_pkg::SC2_RST[scs_pkg::SC2_SYSCK_BIT];
    end else if (wr && idx == scs_pkg::SC2_IDX) begin
      xen_q <= wd[scs_pkg::SC2_XEN_BIT];
      sysck_q <= wd[scs_pkg::SC2_SYSCK_BIT];
    end else if (mode_q == scs_pkg::MODE_WARM && mode_d == scs_pkg::MODE_NORMAL) begin
      xen_q <= 1'b1;
      sysck_q <= 1'b0;
    end
  end

  // idle bit: cleared on wake, a software set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= scs_pkg::SC2_RST[scs_pkg::SC2_IDLE_BIT];
    end else if (wr && idx == scs_pkg::SC2_IDX) begin
      idle_q <= wd[scs_pkg::SC2_IDLE_BIT];
    end else if (mode_q == scs_pkg::MODE_IDLE && mode_d == scs_pkg::MODE_NORMAL) begin
      idle_q <= 1'b0;
    end
  end

  // oscillator switched off by software resets the device
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= wr && idx == scs_pkg::SC2_IDX && !wd[scs_pkg::SC2_XEN_BIT];
    end
  end
  assign sysResetReq = rst_q;

  // ****************************************
  // release pin filter
  // ****************************************
  logic [2:0] pinS_q;
  logic pinF_q;
  logic pinP_q;
  logic relEvt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinS_q <= 3'h0;
      pinF_q <= 1'b0;
      pinP_q <= 1'b0;
    end else begin
      pinS_q <= {pinS_q[1:0], stopReleasePin};
      if (pinS_q[1] == pinS_q[2]) begin
        pinF_q <= pinS_q[2];
      end
      pinP_q <= pinF_q;
    end
  end
  assign relEvt = stop_release_select_q ? pinF_q : (pinF_q && !pinP_q);

  // ****************************************
  // mode control
  // ****************************************
  logic wake;
  logic warmDone;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] warmTgt;

  assign wake = irqPeriph || irqExt;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      scs_pkg::MODE_NORMAL: begin
        if (stop_q) begin
          mode_d = (stop_release_select_q && pinF_q) ? scs_pkg::MODE_WARM : scs_pkg::MODE_STOP;
        end else if (idle_q) begin
          mode_d = scs_pkg::MODE_IDLE;
        end
      end
      scs_pkg::MODE_IDLE: begin
        if (wake) begin
          mode_d = scs_pkg::MODE_NORMAL;
        end
      end
      scs_pkg::MODE_STOP: begin
        if (relEvt) begin
          mode_d = scs_pkg::MODE_WARM;
        end
      end
      scs_pkg::MODE_WARM: begin
        if (warmDone) begin
          mode_d = scs_pkg::MODE_NORMAL;
        end
      end
      default: begin
        mode_d = scs_pkg::MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= scs_pkg::MODE_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign mode = mode_q;

  // clock gates follow the mode
  assign clkEn.osc = xen_q && mode_q != scs_pkg::MODE_STOP;
  assign clkEn.cpu = mode_q == scs_pkg::MODE_NORMAL;
  assign clkEn.wdt = mode_q == scs_pkg::MODE_NORMAL;
  assign clkEn.periph = mode_q == scs_pkg::MODE_NORMAL || mode_q == scs_pkg::MODE_IDLE;
  assign clkEn.portHold = mode_q == scs_pkg::MODE_STOP && outen_q;

  // wake outcome depends on master enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      takeIrq <= 1'b0;
      resumeNext <= 1'b0;
    end else begin
      takeIrq <= mode_q == scs_pkg::MODE_IDLE && wake && interruptMasterEnable;
      resumeNext <= mode_q == scs_pkg::MODE_IDLE && wake && !interruptMasterEnable;
    end
  end

  // ****************************************
  // timing generator
  // ****************************************
  logic clrDiv;
  logic [CW-1:0] carry;

  assign clrDiv = (mode_d != mode_q) &&
    (mode_d == scs_pkg::MODE_STOP || mode_q == scs_pkg::MODE_STOP || mode_d == scs_pkg::MODE_WARM);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (clrDiv) begin
      cnt_q <= '0;
    end else if (mode_q != scs_pkg::MODE_STOP) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_comb begin
    carry[0] = cnt_q[0];
    for (int k = 1; k < CW; k++) begin
      carry[k] = carry[k-1] && cnt_q[k];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ticks <= '0;
    end else begin
      ticks.divOut <= tbt_q[scs_pkg::TBT_DIVOUT_ENABLE_BIT] &&
        carry[scs_pkg::DVO_TAP[tbt_q[scs_pkg::TBT_DIVOUT_FREQ_SEL_LSB+:2]]];
      ticks.tbt <= tbt_q[scs_pkg::TBT_EN_BIT] && carry[scs_pkg::TBT_TAP[tbt_q[scs_pkg::TBT_CK_LSB+:3]]];
      ticks.wdt <= clkEn.wdt && carry[scs_pkg::WDT_TAP];
      ticks.tmr <= clkEn.periph && carry[scs_pkg::TMR_TAP];
      ticks.warm <= mode_q == scs_pkg::MODE_WARM && carry[scs_pkg::WARM_TAP];
    end
  end

  // warm-up length from the code and divider input select
  always_comb begin
    case (wut_q)
      2'b00: warmTgt = CW'(WarmLongCycles);
      2'b01: warmTgt = CW'(WarmMidCycles);
      default: warmTgt = CW'(WarmShortCycles);
    endcase
    if (divider_input_select_q) begin
      warmTgt = warmTgt << 1;
    end
  end
  assign warmDone = cnt_q == warmTgt - 1'b1;

  // ****************************************
  // machine cycle counter
  // ****************************************
  logic [1:0] st_q;
  logic [3:0] cyc_q;
  logic [3:0] lenEff;
  logic done_q;

  assign lenEff = (instrLen == 4'h0) ? 4'h1 : instrLen;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= 2'h0;
      cyc_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (clrDiv) begin
        st_q <= 2'h0;
        cyc_q <= 4'h0;
      end else if (clkEn.cpu) begin
        st_q <= st_q + 2'h1;
        if (st_q == 2'h3) begin
          if (cyc_q + 4'h1 >= lenEff) begin
            cyc_q <= 4'h0;
            done_q <= 1'b1;
          end else begin
            cyc_q <= cyc_q + 4'h1;
          end
        end
      end
    end
  end
  assign mcState = st_q;
  assign instrDone = done_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_stop_entry;
    mode_q == scs_pkg::MODE_NORMAL && stop_q && !(stop_release_select_q && pinF_q);
  endsequence

  div_clear_a: assert property (s_stop_entry |=> cnt_q == '0 && mode_q == scs_pkg::MODE_STOP)
    else $error("divider not cleared on stop entry");
  stop_hold_a: assert property (mode_q == scs_pkg::MODE_STOP && !clrDiv |=> $stable(cnt_q) && !clkEn.osc)
    else $error("chain moved in stop");
  idle_gate_a: assert property (mode_q == scs_pkg::MODE_IDLE |-> !clkEn.cpu && !clkEn.wdt && clkEn.periph)
    else $error("idle clock gating wrong");
  idle_wake_a: assert property (mode_q == scs_pkg::MODE_IDLE && wake |=> mode_q == scs_pkg::MODE_NORMAL && !idle_q)
    else $error("idle not left on interrupt");
  wake_irq_a: assert property (mode_q == scs_pkg::MODE_IDLE && wake |=> takeIrq == $past(interruptMasterEnable) && resumeNext != takeIrq)
    else $error("wake outcome wrong");
  cycle_walk_a: assert property (clkEn.cpu && mode_d == scs_pkg::MODE_NORMAL |=> st_q == 2'($past(st_q) + 2'h1))
    else $error("machine states out of order");
  stop_clear_a: assert property (mode_q == scs_pkg::MODE_STOP && relEvt && !wr |=> !stop_q && mode_q == scs_pkg::MODE_WARM)
    else $error("stop bit not cleared on release");
  level_rel_a: assert property (mode_q == scs_pkg::MODE_STOP && stop_release_select_q && pinF_q |=> mode_q == scs_pkg::MODE_WARM)
    else $error("level release missed");
  warm_len_a: assert property (mode_q == scs_pkg::MODE_WARM |-> cnt_q < warmTgt)
    else $error("warm-up overran");
  warm_end_a: assert property (mode_q == scs_pkg::MODE_WARM && cnt_q == warmTgt - 1'b1 |=> mode_q == scs_pkg::MODE_NORMAL && xen_q)
    else $error("warm-up did not end");
  tbt_bit4_a: assert property (tbt_q[4] == 1'b0)
    else $error("time base bit four set");

endmodule

/* File: tb/scs_cpu_model.sv */
// ****
// core and interrupt controller model
// ****
module scs_cpu_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] lenCmd,
  input wire logic irqCmdP,
  input wire logic irqCmdE,
  input wire logic imfCmd,
  input wire logic instrDone,
  input wire logic takeIrq,
  input wire logic resumeNext,
  output logic [3:0] instrLen,
  output logic irqPeriph,
  output logic irqExt,
  output logic interruptMasterEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  // requests held until the core answers them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqPeriph <= 1'b0;
      irqExt <= 1'b0;
    end else if (takeIrq || resumeNext) begin
      irqPeriph <= 1'b0;
      irqExt <= 1'b0;
    end else begin
      if (irqCmdP) irqPeriph <= 1'b1;
      if (irqCmdE) irqExt <= 1'b1;
    end
  end
  // next instruction length loaded per instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) instrLen <= 4'h1;
    else if (instrDone) instrLen <= lenCmd;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) interruptMasterEnable <= 1'b0;
    else interruptMasterEnable <= imfCmd;
  end
endmodule

/* File: tb/test_scs_clock_standby.sv */
module test_scs_clock_standby;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals and instances
  // ****
  logic clk, arst_n, wbCyc, wbStb, wbWe, wbAck, stopReleasePin, irqPeriph, irqExt, interruptMasterEnable;
  logic [7:0] wbAdr, rd, v;
  logic [3:0] wbSel, instrLen, lenCmd;
  logic [31:0] wbDatW, wbDatR;
  logic irqCmdP, irqCmdE, imfCmd, instrDone, takeIrq, resumeNext, sysResetReq;
  logic [1:0] mcState, s;
  scs_pkg::scs_clk_en_type clkEn;
  scs_pkg::scs_tick_type ticks;
  scs_pkg::scs_mode_type mode;
  int failCount, checks, seed, n, len, b;
  logic [7:0] ri [6];
  logic [7:0] rv [6];

  scs_clock_standby #(.WarmLongCycles(24), .WarmMidCycles(8), .WarmShortCycles(4)) DUT (
    .clk(clk), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .stopReleasePin(stopReleasePin), .irqPeriph(irqPeriph),
    .irqExt(irqExt), .interruptMasterEnable(interruptMasterEnable), .instrLen(instrLen), .clkEn(clkEn),
    .ticks(ticks), .mcState(mcState), .instrDone(instrDone), .takeIrq(takeIrq), .resumeNext(resumeNext),
    .sysResetReq(sysResetReq), .mode(mode));

  scs_cpu_model cpuModel (.clk(clk), .arst_n(arst_n), .lenCmd(lenCmd), .irqCmdP(irqCmdP), .irqCmdE(irqCmdE),
    .imfCmd(imfCmd), .instrDone(instrDone), .takeIrq(takeIrq), .resumeNext(resumeNext), .instrLen(instrLen),
    .irqPeriph(irqPeriph), .irqExt(irqExt), .interruptMasterEnable(interruptMasterEnable));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****
  // helpers
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // classic single cycle, held until ack is seen
  task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx[5:0], 2'h0};
    wbDatW <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    check(wbAck, 32'h1);
    q = wbDatR[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic waitMode(input scs_pkg::scs_mode_type m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic waitDone();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (instrDone !== 1'b1 && n < 100);
  endtask

  function automatic int tgt(input int code, input int dv1);
    int w;
    w = (code == 0) ? 24 : (code == 1) ? 8 : 4;
    return w << dv1;
  endfunction

  // stop entry, optional stale high pin, release and warm-up
  task automatic stopRun(input logic [7:0] val, input int target, input logic preHigh);
    logic bad;
    @(posedge clk);
    stopReleasePin <= preHigh;
    repeat (8) @(posedge clk);
    bus(scs_pkg::SC1_IDX, 1'b1, val, rd);
    if (val[6] && preHigh) begin
      waitMode(scs_pkg::MODE_WARM, 6);
      check(mode, scs_pkg::MODE_WARM);
    end else begin
      waitMode(scs_pkg::MODE_STOP, 6);
      check(mode, scs_pkg::MODE_STOP);
      check(clkEn, 5'h01);
      s = mcState;
      bad = 1'b0;
      repeat (12) begin
        @(negedge clk);
        bad |= (ticks !== 5'h00) || (mcState !== s);
      end
      check(bad, 32'h0);
      if (preHigh) begin
        check(mode, scs_pkg::MODE_STOP);
        @(posedge clk);
        stopReleasePin <= 1'b0;
        repeat (6) @(posedge clk);
      end
      @(posedge clk);
      stopReleasePin <= 1'b1;
      waitMode(scs_pkg::MODE_WARM, 8);
      check(mode, scs_pkg::MODE_WARM);
    end
    n = 0;
    while (mode === scs_pkg::MODE_WARM && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(n, target);
    check(mode, scs_pkg::MODE_NORMAL);
    bus(scs_pkg::SC1_IDX, 1'b0, 8'h00, rd);
    check(rd[7], 32'h0);
    stopReleasePin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // ****
  // sequence
  // ****
  initial begin
    seed = 34;
    {wbCyc, wbStb, wbWe, stopReleasePin, irqCmdP, irqCmdE, imfCmd} = 7'h00;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatW = 32'h0;
    lenCmd = 4'h1;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    check(clkEn, 5'h1e);
    ri = '{scs_pkg::TBT_IDX, scs_pkg::DIV_IDX, scs_pkg::SC1_IDX, scs_pkg::SC2_IDX, scs_pkg::STAT_IDX, 8'h3b};
    rv = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h01, 8'h00};
    for (int i = 0; i < 6; i++) begin
      bus(ri[i], 1'b0, 8'h00, rd);
      check(rd & 8'he7, rv[i]);
    end
    bus(8'h3b, 1'b1, 8'hff, rd);
    bus(8'h3b, 1'b0, 8'h00, rd);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 8'hef;
      bus(scs_pkg::TBT_IDX, 1'b1, v, rd);
      bus(scs_pkg::TBT_IDX, 1'b0, 8'h00, rd);
      check(rd, v);
    end
    bus(scs_pkg::DIV_IDX, 1'b1, 8'h20, rd);
    bus(scs_pkg::DIV_IDX, 1'b0, 8'h00, rd);
    check(rd & 8'he7, 8'h20);
    bus(scs_pkg::DIV_IDX, 1'b1, 8'h00, rd);
    for (int i = 0; i < 6; i++) begin
      len = (i == 0) ? 1 : (i == 1) ? 15 : 1 + ($unsigned($random(seed)) % 15);
      @(posedge clk);
      lenCmd <= len[3:0];
      waitDone();
      waitDone();
      waitDone();
      check(n, 4 * len);
      s = mcState;
      @(negedge clk);
      check(mcState, 2'(s + 2'h1));
    end
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk);
      imfCmd <= k[0];
      bus(scs_pkg::SC2_IDX, 1'b1, 8'h90, rd);
      waitMode(scs_pkg::MODE_IDLE, 6);
      check(mode, scs_pkg::MODE_IDLE);
      check(clkEn, 5'h12);
      @(posedge clk);
      if (k == 1) irqCmdP <= 1'b1;
      else irqCmdE <= 1'b1;
      @(posedge clk);
      irqCmdP <= 1'b0;
      irqCmdE <= 1'b0;
      n = 0;
      while (takeIrq !== 1'b1 && resumeNext !== 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      check({takeIrq, resumeNext}, (k == 1) ? 2'h2 : 2'h1);
      check(mode, scs_pkg::MODE_NORMAL);
      bus(scs_pkg::SC2_IDX, 1'b0, 8'h00, rd);
      check(rd, 8'h80);
    end
    for (int c = 0; c < 3; c++) stopRun(8'h90 | 8'(c << 2), tgt(c, 0), 1'b0);
    bus(scs_pkg::DIV_IDX, 1'b1, 8'h20, rd);
    stopRun(8'h94, tgt(1, 1), 1'b1);
    bus(scs_pkg::DIV_IDX, 1'b1, 8'h00, rd);
    stopRun(8'hd0, tgt(0, 0), 1'b1);
    stopRun(8'hd8, tgt(2, 0), 1'b0);
    bus(scs_pkg::TBT_IDX, 1'b1, 8'hef, rd);
    for (int t = 0; t < 3; t++) begin
      b = (t == 0) ? 4 : (t == 1) ? 3 : 1;
      n = 0;
      while (ticks[b] !== 1'b1 && n < 20000) begin
        @(negedge clk);
        n++;
      end
      check(ticks[b], 32'h1);
    end
    results();
  end

  initial begin
    repeat (90000) @(posedge clk);
    failCount++;
    results();
  end
endmodule
